// File: hdl/dsl_link_map.svh
// Constants for the data/strobe link start-up and reset controller.
// Included by the bit divider, the link controller and the checker; holds definitions only.
`ifndef DSL_LINK_MAP_SVH
`define DSL_LINK_MAP_SVH

`define DSL_NLINK 4
`define DSL_AW 4
// Register index within a link, address bits [1:0]; link number in [3:2]
`define DSL_REG_MODE 2'h0
`define DSL_REG_CMD 2'h1
`define DSL_REG_STAT 2'h2
`define DSL_REG_LOCK 2'h3
// Command bits
`define DSL_CMD_RESET 0
`define DSL_CMD_GO 1
`define DSL_CMD_LOW 2
`define DSL_CMD_BADPAR 3
// Status bits
`define DSL_ST_FAULT 0
`define DSL_ST_STARTED 1
`define DSL_ST_LOWDONE 2
`define DSL_ST_PARITY 3
`define DSL_ST_DISC 4
`define DSL_ST_TOKEN 5
`define DSL_ST_W 6
// Timing
`define DSL_CLK_MHZ 200
`define DSL_BIT_MIN_NS 10
`define DSL_BIT_MAX_NS 100
`define DSL_BIT_MIN_CYC ((`DSL_BIT_MIN_NS * `DSL_CLK_MHZ + 999) / 1000)
`define DSL_BIT_MAX_CYC ((`DSL_BIT_MAX_NS * `DSL_CLK_MHZ) / 1000)
`define DSL_HOLD_NS 12800
`define DSL_HOLD_CYC ((`DSL_HOLD_NS * `DSL_CLK_MHZ + 999) / 1000)
`define DSL_DISC_NS 850
`define DSL_DISC_CYC ((`DSL_DISC_NS * `DSL_CLK_MHZ + 999) / 1000)
`define DSL_PERIOD_RST 5'h14
// Token layer
`define DSL_CODE_FCT 2'h0
`define DSL_CODE_ESC 2'h3
`define DSL_CTL_LEN 4'h4
`define DSL_NUL_LEN 4'h8
`define DSL_DATA_LEN 4'hA
`define DSL_FCT_GRANTS 2'h2
`define DSL_CREDIT_STEP 7'h08
// Soft reset levels
`define DSL_LVL_KEEP_PINS 2'h2

`endif

// File: hdl/dsl_pkg.sv
// Types shared by the link controller modules.
// Assumes the constants header is compiled alongside.
package dsl_pkg;
  typedef enum logic [2:0] {
    DSL_IDLE = 3'b000,
    DSL_HOLD = 3'b001,
    DSL_NULS = 3'b010,
    DSL_FCTS = 3'b011,
    DSL_RUN = 3'b100
  } dsl_state_t;
  typedef logic [4:0] dsl_period_t;
endpackage

// File: hdl/dsl_rate_if.sv
// Bit-rate handshake between a link engine and its bit divider.
// Both ends run on the single system clock.
`timescale 1ns/1ps
interface dsl_rate_if;
  dsl_pkg::dsl_period_t period;
  logic restart;
  logic tick;
  modport ctl(output period, output restart, input tick);
  modport div(input period, input restart, output tick);
endinterface

// File: hdl/dsl_sync.sv
// Two-flop synchroniser for pin inputs.
// Assumes inputs are asynchronous to clk; nothing reads the first stage.
`timescale 1ns/1ps
module dsl_sync #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Data
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] stage1;

  always_ff @(posedge clk) begin
    if (rst) begin
      stage1 <= '0;
      dout <= '0;
    end else begin
      stage1 <= din;
      dout <= stage1;
    end
  end
endmodule

// File: hdl/dsl_bit_div.sv
// Bit-period divider: one-cycle tick every period clocks.
// Assumes period is already clamped to the legal range by the caller.
`timescale 1ns/1ps
`include "dsl_link_map.svh"
module dsl_bit_div (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Rate control
  dsl_rate_if.div rate
);
  import dsl_pkg::*;
  dsl_period_t cnt;

  always_ff @(posedge clk) begin
    if (rst || rate.restart) begin
      cnt <= 5'h00;
      rate.tick <= 1'b0;
    end else if (cnt + 5'h01 >= rate.period) begin
      cnt <= 5'h00;
      rate.tick <= 1'b1;
    end else begin
      cnt <= cnt + 5'h01;
      rate.tick <= 1'b0;
    end
  end
endmodule

// File: hdl/dsl_link_ctl.sv
// Four-channel data/strobe link start-up, reset and flow-control gating.
// Assumes link pins are asynchronous, request pulses are on clk.
`timescale 1ns/1ps
`include "dsl_link_map.svh"
module dsl_link_ctl (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [`DSL_AW-1:0] addr,
  input wire logic [31:0] wrData,
  input wire logic wrEn,
  input wire logic rdEn,
  input wire logic wrFromCpu,
  output logic [31:0] rdData,
  // Reset and channel requests, one-cycle pulses
  input wire logic softRst,
  input wire logic [1:0] softRstLevel,
  input wire logic globalReset,
  input wire logic ctrlLinkReset,
  input wire logic [`DSL_NLINK-1:0] chanResetReq,
  input wire logic [`DSL_NLINK-1:0] modeZeroReq,
  // Transmit data, one byte per link
  input wire logic [8*`DSL_NLINK-1:0] txData,
  input wire logic [`DSL_NLINK-1:0] txValid,
  output logic [`DSL_NLINK-1:0] txTaken,
  output logic [`DSL_NLINK-1:0] queueClear,
  // Received data
  output logic [8*`DSL_NLINK-1:0] rxData,
  output logic [`DSL_NLINK-1:0] rxStrobe,
  // Link pins
  input wire logic [`DSL_NLINK-1:0] dataIn,
  input wire logic [`DSL_NLINK-1:0] strobeIn,
  output logic [`DSL_NLINK-1:0] dataOut,
  output logic [`DSL_NLINK-1:0] strobeOut
);
  import dsl_pkg::*;

  function automatic logic regHit(input logic [`DSL_AW-1:0] a, input int lk,
                                  input logic [1:0] r);
    regHit = (a[3:2] == lk[1:0]) && (a[1:0] == r);
  endfunction

  logic [2*`DSL_NLINK-1:0] pinSync;
  logic [`DSL_ST_W*`DSL_NLINK-1:0] statAll;
  logic [5*`DSL_NLINK-1:0] periodAll;
  logic [`DSL_NLINK-1:0] lockAll;
  wire pinsLowRst = softRst && (softRstLevel != `DSL_LVL_KEEP_PINS);
  wire [1:0] rdLink = addr[3:2];

  // Pins cross into clk before any decoding
  dsl_sync #(.W(2*`DSL_NLINK)) u_sync (
    .clk(clk),
    .rst(rst),
    .din({strobeIn, dataIn}),
    .dout(pinSync)
  );

  always_ff @(posedge clk) begin
    if (rst) begin
      rdData <= 32'h00000000;
    end else if (rdEn) begin
      case (addr[1:0])
        `DSL_REG_MODE: rdData <= {27'h0000000, periodAll[rdLink*5 +: 5]};
        `DSL_REG_STAT: rdData <= {26'h0000000, statAll[rdLink*6 +: 6]};
        `DSL_REG_LOCK: rdData <= {31'h00000000, lockAll[rdLink]};
        default: rdData <= 32'h00000000;
      endcase
    end
  end

  for (genvar i = 0; i < `DSL_NLINK; i++) begin : g_link
    dsl_rate_if rate();
    dsl_bit_div u_div (
      .clk(clk),
      .rst(rst),
      .rate(rate.div)
    );

    dsl_state_t state;
    dsl_period_t period;
    logic lock, goPrev, go, badPar;
    logic [11:0] holdCnt;
    logic [9:0] txShift;
    logic [3:0] txLen;
    logic txAcc;
    logic [1:0] fctLeft;
    logic [6:0] credit;
    logic dOut, sOut, outLowDone;
    logic pd, ps, rxP, rxFlag, rxAcc, escSeen, seenBit;
    logic [3:0] rxCnt;
    logic [7:0] rxSh;
    logic [7:0] silence;
    logic faultFlag, parFlag, discFlag, tokSeen;

    wire dS = pinSync[i];
    wire sS = pinSync[`DSL_NLINK + i];
    wire wrOk = wrEn && (!wrFromCpu || !lock);
    wire cmdWr = wrOk && regHit(addr, i, `DSL_REG_CMD);
    wire modeWr = wrOk && regHit(addr, i, `DSL_REG_MODE);
    wire lockWr = wrOk && regHit(addr, i, `DSL_REG_LOCK);
    wire startEv = (cmdWr && wrData[`DSL_CMD_GO] && !goPrev) || chanResetReq[i];
    wire rstCmd = (cmdWr && wrData[`DSL_CMD_RESET]) || modeZeroReq[i];
    wire lowCmd = cmdWr && wrData[`DSL_CMD_LOW];
    // Receiver decode
    wire bitEv = (dS ^ pd) || (sS ^ ps);
    wire lastBit = rxFlag ? (rxCnt == `DSL_CTL_LEN - 4'h1) : (rxCnt == `DSL_DATA_LEN - 4'h1);
    wire tokDone = bitEv && (rxCnt > 4'h1) && lastBit;
    wire [1:0] rxCode = {dS, rxSh[7]};
    wire [7:0] rxByte = {dS, rxSh[7:1]};
    wire parEv = bitEv && (rxCnt == 4'h1) && ((rxP ^ dS ^ rxAcc) != 1'b1);
    wire discEv = seenBit && !bitEv && (silence == 8'(`DSL_DISC_CYC - 1));
    wire errEv = (parEv || discEv) && (state != DSL_HOLD);
    wire fctIn = tokDone && rxFlag && (rxCode == `DSL_CODE_FCT) && !escSeen;
    // Any of these resets the engines and enforces the hold-off
    wire engRst = rstCmd || startEv || globalReset || softRst || errEv;
    wire sending = (state == DSL_NULS) || (state == DSL_FCTS) || (state == DSL_RUN);
    wire canSend = (state == DSL_RUN) && txValid[i] && (credit != 7'h00);
    wire loadTok = rate.tick && sending && (txLen == 4'h0) && !engRst;
    wire emitBit = rate.tick && (txLen != 4'h0) && sending && !engRst;
    wire pFirst = badPar ^ (canSend ? ~txAcc : txAcc);
    wire [7:0] txByte = txData[8*i +: 8];
    wire [6:0] creditAdd = fctIn ? `DSL_CREDIT_STEP : 7'h00;
    wire [6:0] creditSub = (loadTok && canSend) ? 7'h01 : 7'h00;

    assign rate.period = period;
    assign rate.restart = engRst;
    assign dataOut[i] = dOut;
    assign strobeOut[i] = sOut;
    assign periodAll[5*i +: 5] = period;
    assign lockAll[i] = lock;
    assign statAll[`DSL_ST_W*i +: `DSL_ST_W] = {tokSeen, discFlag, parFlag, outLowDone,
                                                 sending && !faultFlag, faultFlag};

    // Configuration; only pin-lowering soft resets restore defaults
    always_ff @(posedge clk) begin
      if (rst || pinsLowRst) begin
        period <= `DSL_PERIOD_RST;
        lock <= 1'b0;
        goPrev <= 1'b0;
        badPar <= 1'b0;
      end else begin
        if (modeWr) begin
          if (wrData[4:0] < 5'(`DSL_BIT_MIN_CYC)) begin
            period <= 5'(`DSL_BIT_MIN_CYC);
          end else if (wrData[4:0] > 5'(`DSL_BIT_MAX_CYC)) begin
            period <= 5'(`DSL_BIT_MAX_CYC);
          end else begin
            period <= wrData[4:0];
          end
        end
        if (ctrlLinkReset) begin
          lock <= 1'b0;
        end else if (lockWr) begin
          lock <= wrData[0];
        end
        if (cmdWr) begin
          goPrev <= wrData[`DSL_CMD_GO];
          badPar <= wrData[`DSL_CMD_BADPAR];
        end
      end
    end

    // Start/hold sequencing
    always_ff @(posedge clk) begin
      if (rst) begin
        state <= DSL_IDLE;
        go <= 1'b0;
        holdCnt <= 12'h000;
        fctLeft <= 2'h0;
      end else if (engRst) begin
        state <= DSL_HOLD;
        holdCnt <= 12'(`DSL_HOLD_CYC);
        fctLeft <= `DSL_FCT_GRANTS;
        if (startEv) begin
          go <= 1'b1;
        end else if (!errEv) begin
          go <= 1'b0;
        end
      end else begin
        case (state)
          DSL_IDLE: state <= DSL_IDLE;
          DSL_HOLD: begin
            if (holdCnt != 12'h000) begin
              holdCnt <= holdCnt - 12'h001;
            end else begin
              state <= go ? DSL_NULS : DSL_IDLE;
            end
          end
          DSL_NULS: if (tokSeen) state <= DSL_FCTS;
          DSL_FCTS: begin
            if (loadTok) begin
              fctLeft <= fctLeft - 2'h1;
              if (fctLeft == 2'h1) state <= DSL_RUN;
            end
          end
          DSL_RUN: state <= DSL_RUN;
          default: state <= DSL_IDLE;
        endcase
      end
    end

    // Transmitter: tokens go out LSB first, one bit per tick; loading each token takes a tick of its own
    always_ff @(posedge clk) begin
      if (rst || pinsLowRst) begin
        dOut <= 1'b0;
        sOut <= 1'b0;
        outLowDone <= 1'b0;
        txLen <= 4'h0;
        txShift <= 10'h000;
        txAcc <= 1'b0;
        credit <= 7'h00;
        txTaken[i] <= 1'b0;
        queueClear[i] <= 1'b0;
      end else begin
        txTaken[i] <= 1'b0;
        queueClear[i] <= chanResetReq[i];
        if (lowCmd) begin
          dOut <= 1'b0;
          sOut <= 1'b0;
          outLowDone <= 1'b1;
        end else if (emitBit) begin
          if (txShift[0] != dOut) begin
            dOut <= txShift[0];
          end else begin
            sOut <= ~sOut;
          end
        end
        if (engRst) begin
          // Pins keep their level; only the token engine restarts
          txLen <= 4'h0;
          txAcc <= 1'b0;
          credit <= 7'h00;
        end else begin
          credit <= credit + creditAdd - creditSub;
          if (emitBit) begin
            txShift <= {1'b0, txShift[9:1]};
            txLen <= txLen - 4'h1;
          end else if (loadTok) begin
            if (canSend) begin
              txShift <= {txByte, 1'b0, pFirst};
              txLen <= `DSL_DATA_LEN;
              txAcc <= ^txByte;
              txTaken[i] <= 1'b1;
            end else if (state == DSL_FCTS) begin
              txShift <= {6'h00, 3'b001, pFirst};
              txLen <= `DSL_CTL_LEN;
              txAcc <= 1'b0;
            end else begin
              // Escape then flow-control token forms a null
              txShift <= {2'b00, 4'b0010, 3'b111, pFirst};
              txLen <= `DSL_NUL_LEN;
              txAcc <= 1'b0;
            end
          end
        end
      end
    end

    // Receiver runs whether or not the link has been started
    always_ff @(posedge clk) begin
      if (rst || engRst) begin
        pd <= dS;
        ps <= sS;
        rxCnt <= 4'h0;
        rxP <= 1'b0;
        rxFlag <= 1'b0;
        rxSh <= 8'h00;
        rxAcc <= 1'b0;
        escSeen <= 1'b0;
        seenBit <= 1'b0;
        silence <= 8'h00;
        rxStrobe[i] <= 1'b0;
        rxData[8*i +: 8] <= 8'h00;
      end else begin
        pd <= dS;
        ps <= sS;
        rxStrobe[i] <= 1'b0;
        silence <= bitEv ? 8'h00 : silence + {7'h00, seenBit};
        if (bitEv) begin
          seenBit <= 1'b1;
          if (rxCnt == 4'h0) begin
            rxP <= dS;
            rxCnt <= 4'h1;
          end else if (rxCnt == 4'h1) begin
            rxFlag <= dS;
            rxCnt <= 4'h2;
          end else if (tokDone) begin
            rxCnt <= 4'h0;
            if (rxFlag) begin
              rxAcc <= ^rxCode;
              escSeen <= (rxCode == `DSL_CODE_ESC);
            end else begin
              rxAcc <= ^rxByte;
              escSeen <= 1'b0;
              rxData[8*i +: 8] <= rxByte;
              rxStrobe[i] <= 1'b1;
            end
          end else begin
            rxSh <= {dS, rxSh[7:1]};
            rxCnt <= rxCnt + 4'h1;
          end
        end
      end
    end

    // Status: a new error wins over a clear in the same cycle; an engine reset wins over a new token
    always_ff @(posedge clk) begin
      if (rst) begin
        faultFlag <= 1'b0;
        parFlag <= 1'b0;
        discFlag <= 1'b0;
        tokSeen <= 1'b0;
      end else begin
        if (errEv) begin
          faultFlag <= 1'b1;
        end else if (rstCmd || startEv) begin
          faultFlag <= 1'b0;
        end
        if (errEv && parEv) begin
          parFlag <= 1'b1;
        end else if (rstCmd || startEv) begin
          parFlag <= 1'b0;
        end
        if (errEv && discEv) begin
          discFlag <= 1'b1;
        end else if (rstCmd || startEv) begin
          discFlag <= 1'b0;
        end
        if (tokDone && !engRst) begin
          tokSeen <= 1'b1;
        end else if (engRst) begin
          tokSeen <= 1'b0;
        end
      end
    end
  end
endmodule

// File: tb/dsl_link_ctl_chk.sv
// Port-level checker for the link controller, link 0 start-up and resets.
// Bound to dsl_link_ctl from the bench; assumes link 0 is never write-locked.
`timescale 1ns/1ps
`include "dsl_link_map.svh"
module dsl_link_ctl_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [`DSL_AW-1:0] addr,
  input wire logic [31:0] wrData,
  input wire logic wrEn,
  input wire logic rdEn,
  input wire logic wrFromCpu,
  input wire logic [31:0] rdData,
  // Requests
  input wire logic softRst,
  input wire logic [1:0] softRstLevel,
  input wire logic globalReset,
  input wire logic [`DSL_NLINK-1:0] chanResetReq,
  input wire logic [`DSL_NLINK-1:0] modeZeroReq,
  // Data and pins
  input wire logic [`DSL_NLINK-1:0] txValid,
  input wire logic [`DSL_NLINK-1:0] txTaken,
  input wire logic [`DSL_NLINK-1:0] queueClear,
  input wire logic [`DSL_NLINK-1:0] dataOut,
  input wire logic [`DSL_NLINK-1:0] strobeOut
);
  localparam int HOLD = `DSL_HOLD_CYC;
  logic [11:0] holdCnt;
  wire cmdWr = wrEn && addr == 4'h1;
  wire goWr = cmdWr && wrData[`DSL_CMD_GO];
  wire stopReq = softRst || globalReset || modeZeroReq[0] || (cmdWr && wrData[`DSL_CMD_RESET]);
  // Counts from a start of link 0; parks past the hold so later traffic is not judged
  always_ff @(posedge clk) begin
    if (rst || stopReq) begin
      holdCnt <= 12'h000;
    end else if (goWr) begin
      holdCnt <= 12'h001;
    end else if (holdCnt != 12'h000 && holdCnt <= HOLD) begin
      holdCnt <= holdCnt + 12'h001;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence pinsQuiet;
    $stable(dataOut) && $stable(strobeOut);
  endsequence
  sequence pinMoved;
    !$stable(dataOut[0]) || !$stable(strobeOut[0]);
  endsequence
  AST_RST_LOW: assert property ($fell(rst) |-> (dataOut == 4'h0 && strobeOut == 4'h0) [*8])
    else $error("pins not low and still after reset");
  AST_SOFT_LOW: assert property (softRst && softRstLevel != 2'h2 |=> dataOut == 4'h0 && strobeOut == 4'h0)
    else $error("soft reset left pins high");
  AST_SOFT_KEEP: assert property (softRst && softRstLevel == `DSL_LVL_KEEP_PINS |=> pinsQuiet)
    else $error("level 2 reset moved pins");
  AST_CMD_RD0: assert property (rdEn && addr[1:0] == `DSL_REG_CMD |=> rdData == 32'h0)
    else $error("command register readable");
  AST_QCLR: assert property (chanResetReq[0] |=> queueClear[0] ##1 !queueClear[0])
    else $error("queue clear pulse wrong");
  AST_HOLD: assert property (holdCnt > 12'h001 && holdCnt <= HOLD |-> pinsQuiet)
    else $error("pins moved in hold-off");
  AST_NUL: assert property (holdCnt == HOLD |=> ##[0:99] pinMoved)
    else $error("no tokens after hold-off");
  AST_GLB: assert property (globalReset |=> pinsQuiet [*8])
    else $error("link active after global reset");
  AST_ENG: assert property (cmdWr && wrData[`DSL_CMD_RESET] |=> pinsQuiet [*8])
    else $error("link active after engine reset");
  AST_LOW: assert property (cmdWr && !wrFromCpu && wrData[`DSL_CMD_LOW] |=> !dataOut[0] && !strobeOut[0])
    else $error("pin-low command ignored");
  AST_TAKEN: assert property (txTaken[0] |-> $past(txValid[0]))
    else $error("byte taken without valid");
endmodule

// File: tb/dsl_far_end.sv
// Behavioural far-end link engine attached to link 0.
// Sends on its own timebase; decodes the block's pins by sampling on clk.
`timescale 1ns/1ps
module dsl_far_end (
  // Sampling clock
  input wire logic clk,
  // Lines from the block
  input wire logic rxD,
  input wire logic rxS,
  // Lines into the block
  output logic txD,
  output logic txS
);
  int nFct = 0, nNul = 0, nData = 0, cnt = 0, nBad = 0;
  // Running data parity of the block's tokens, for the odd-parity check
  logic accPrev = 1'b0;
  logic [7:0] lastByte = 8'h00;
  logic [9:0] sh = 10'h000;
  logic esc = 1'b0, prevX = 1'b0, lastD = 1'b0, lastS = 1'b0;
  initial begin
    txD = 1'b0;
    txS = 1'b0;
  end
  task automatic restart;
    cnt = 0;
    esc = 1'b0;
    prevX = 1'b0;
    nFct = 0;
    nNul = 0;
    nData = 0;
    nBad = 0;
    accPrev = 1'b0;
  endtask
  // 62.5 ns bits, unrelated to clk phase, inside the 10..100 ns window
  task automatic sendTok(input logic flag, input logic [7:0] pay);
    logic [9:0] t;
    t = {pay, flag, ~(prevX ^ flag)};
    for (int i = 0; i < (flag ? 4 : 10); i++) begin
      if (t[i] != txD) txD = t[i];
      else txS = ~txS;
      #62.5;
    end
    prevX = flag ? ^pay[1:0] : ^pay;
  endtask
  task automatic sendNul;
    sendTok(1'b1, 8'h03);
    sendTok(1'b1, 8'h00);
  endtask
  // Data only after the block grants credit; the bench orders the calls
  always @(posedge clk) begin
    lastD <= rxD;
    lastS <= rxS;
    if (rxD !== lastD || rxS !== lastS) begin
      sh[cnt] = rxD;
      cnt = cnt + 1;
      if (cnt >= 2 && cnt == (sh[1] ? 4 : 10)) begin
        if ((sh[0] ^ sh[1] ^ accPrev) !== 1'b1) nBad++;
        accPrev = sh[1] ? ^sh[3:2] : ^sh[9:2];
        if (!sh[1]) begin
          nData++;
          lastByte = sh[9:2];
        end else if (sh[3:2] == 2'b00) begin
          if (esc) nNul++;
          else nFct++;
        end
        esc = sh[1] && sh[3:2] == 2'b11;
        cnt = 0;
      end
    end
  end
endmodule

// File: tb/tb.sv
// Self-checking bench for the link controller; far end on link 0 only.
// Assumes the design and checker files are compiled first.
`timescale 1ns/1ps
bind dsl_link_ctl dsl_link_ctl_chk u_chk (.clk(clk), .rst(rst), .addr(addr), .wrData(wrData),
  .wrEn(wrEn), .rdEn(rdEn), .wrFromCpu(wrFromCpu), .rdData(rdData), .softRst(softRst),
  .softRstLevel(softRstLevel), .globalReset(globalReset), .chanResetReq(chanResetReq),
  .modeZeroReq(modeZeroReq), .txValid(txValid), .txTaken(txTaken), .queueClear(queueClear),
  .dataOut(dataOut), .strobeOut(strobeOut));
module tb;
  logic clk = 1'b0, rst = 1'b1, wrEn = 1'b0, rdEn = 1'b0, wrFromCpu = 1'b1;
  logic softRst = 1'b0, globalReset = 1'b0, ctrlLinkReset = 1'b0, rxSeen = 1'b0;
  logic [1:0] softRstLevel = 2'h0;
  logic [3:0] addr = 4'h0, chanResetReq = 4'h0, modeZeroReq = 4'h0, txValid = 4'h1;
  logic [31:0] wrData = 32'h0, txData = 32'h3C, rdData, rxData;
  logic [3:0] txTaken, queueClear, rxStrobe, dataOut, strobeOut;
  logic farD, farS;
  logic [7:0] rxByte = 8'h00;
  int takenCnt = 0, mismatches = 0, testsRun = 0, c;
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    if (rxStrobe[0] === 1'b1) begin
      rxSeen <= 1'b1;
      rxByte <= rxData[7:0];
    end
    if (txTaken[0] === 1'b1) takenCnt <= takenCnt + 1;
  end
  dsl_link_ctl u_dut (.clk(clk), .rst(rst), .addr(addr), .wrData(wrData), .wrEn(wrEn),
    .rdEn(rdEn), .wrFromCpu(wrFromCpu), .rdData(rdData), .softRst(softRst),
    .softRstLevel(softRstLevel), .globalReset(globalReset), .ctrlLinkReset(ctrlLinkReset),
    .chanResetReq(chanResetReq), .modeZeroReq(modeZeroReq), .txData(txData),
    .txValid(txValid), .txTaken(txTaken), .queueClear(queueClear), .rxData(rxData),
    .rxStrobe(rxStrobe), .dataIn({3'h0, farD}), .strobeIn({3'h0, farS}),
    .dataOut(dataOut), .strobeOut(strobeOut));
  dsl_far_end u_far (.clk(clk), .rxD(dataOut[0]), .rxS(strobeOut[0]), .txD(farD), .txS(farS));
  task automatic summarize;
    $display("checks %0d mismatches %0d", testsRun, mismatches);
    if (mismatches == 0 && testsRun > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    testsRun++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("MISMATCH at %0t: %s", $time, m);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic cpu);
    @(posedge clk);
    addr <= a;
    wrData <= d;
    wrFromCpu <= cpu;
    wrEn <= 1'b1;
    @(posedge clk);
    wrEn <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rdEn <= 1'b1;
    @(posedge clk);
    rdEn <= 1'b0;
    #1;
    chk((rdData & m) === e, "read value");
  endtask
  // Pin changes on link 0 over n cycles
  task automatic moves(input int n, output int k);
    logic d, s;
    k = 0;
    repeat (n) begin
      d = dataOut[0];
      s = strobeOut[0];
      @(posedge clk);
      #1;
      if (dataOut[0] !== d || strobeOut[0] !== s) k++;
    end
  endtask
  task automatic waitMove(input int n);
    int k;
    k = 0;
    for (int i = 0; i < n && k == 0; i++) moves(1, k);
    chk(k == 1, "link never sent");
    if (k != 1) summarize();
  endtask
  task automatic testReset;
    for (int i = 0; i < 4; i++) begin
      rd({i[1:0], 2'h2}, 32'h3F, 32'h0);
      rd({i[1:0], 2'h0}, 32'h1F, `DSL_PERIOD_RST);
    end
    rd(4'h1, 32'hF, 32'h0);
    chk(dataOut === 4'h0 && strobeOut === 4'h0, "pins not low");
    $display("reset test done");
  endtask
  task automatic testLock;
    wr(4'h7, 32'h1, 1'b1);
    wr(4'h4, 32'h3, 1'b1);
    rd(4'h4, 32'h1F, 32'h14);
    wr(4'h4, 32'h5, 1'b0);
    rd(4'h4, 32'h1F, 32'h5);
    @(posedge clk);
    ctrlLinkReset <= 1'b1;
    @(posedge clk);
    ctrlLinkReset <= 1'b0;
    rd(4'h7, 32'h1, 32'h0);
    wr(4'h6, 32'h3F, 1'b1);
    rd(4'h6, 32'h3F, 32'h0);
    $display("lock test done");
  endtask
  task automatic testRxIdle;
    u_far.sendNul();
    repeat (10) @(posedge clk);
    rd(4'h2, 32'h20, 32'h20);
    chk(dataOut[0] === 1'b0 && strobeOut[0] === 1'b0, "idle link sent");
    wr(4'h1, 32'h1, 1'b1);
    rd(4'h2, 32'h21, 32'h0);
    $display("idle receive test done");
  endtask
  task automatic testStart;
    u_far.restart();
    wr(4'h0, 32'h1, 1'b1);
    wr(4'h1, 32'h2, 1'b1);
    moves(2500, c);
    chk(c == 0, "moved in hold-off");
    waitMove(200);
    moves(180, c);
    chk(c >= 79 && c <= 81, "bit period");
    chk(u_far.nNul > 0 && u_far.nFct == 0 && u_far.nData == 0, "start tokens");
    rd(4'h2, 32'h2, 32'h2);
    $display("start test done");
  endtask
  task automatic testCredit;
    repeat (3) u_far.sendNul();
    repeat (100) @(posedge clk);
    chk(u_far.nFct == 2 && u_far.nData == 0 && takenCnt == 0, "credit grant");
    u_far.sendTok(1'b0, 8'hA5);
    u_far.sendTok(1'b1, 8'h00);
    repeat (4) u_far.sendNul();
    chk(rxSeen === 1'b1 && rxByte === 8'hA5, "received byte");
    chk(u_far.nData == 8 && u_far.lastByte === 8'h3C && takenCnt == 8, "data flow");
    chk(u_far.nBad == 0, "bad token parity");
    $display("credit test done");
  endtask
  task automatic testFault;
    repeat (250) @(posedge clk);
    moves(1500, c);
    chk(c == 0, "pins moved after fault");
    rd(4'h2, 32'h13, 32'h11);
    rd(4'h0, 32'h1F, 32'h2);
    u_far.restart();
    waitMove(1500);
    wr(4'h1, 32'h8, 1'b1);
    moves(100, c);
    chk(u_far.nBad > 0, "wrong parity not forced");
    $display("fault test done");
  endtask
  task automatic testResets;
    @(posedge clk);
    chanResetReq <= 4'h1;
    @(posedge clk);
    chanResetReq <= 4'h0;
    #1;
    chk(queueClear[0] === 1'b1, "queue clear");
    moves(2000, c);
    chk(c == 0, "no hold after channel reset");
    waitMove(800);
    wr(4'h1, 32'h4, 1'b0);
    #1;
    chk(dataOut[0] === 1'b0 && strobeOut[0] === 1'b0, "pins not forced low");
    rd(4'h2, 32'h4, 32'h4);
    @(posedge clk);
    modeZeroReq <= 4'h1;
    @(posedge clk);
    modeZeroReq <= 4'h0;
    moves(100, c);
    chk(c == 0, "link ran after mode zero");
    @(posedge clk);
    softRstLevel <= 2'h2;
    softRst <= 1'b1;
    @(posedge clk);
    softRst <= 1'b0;
    globalReset <= 1'b1;
    @(posedge clk);
    globalReset <= 1'b0;
    softRstLevel <= 2'h0;
    softRst <= 1'b1;
    @(posedge clk);
    softRst <= 1'b0;
    #1;
    chk(dataOut === 4'h0 && strobeOut === 4'h0, "soft reset pins");
    rd(4'h0, 32'h1F, 32'h14);
    $display("reset paths test done");
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    testReset();
    testLock();
    testRxIdle();
    testStart();
    testCredit();
    testFault();
    testResets();
    summarize();
  end
endmodule
